// *** rtl/pbc_core.sv ***
// Priority encoder and BCD-to-binary converter with register port.
// Assumes synchronous register strobes, one op per write of the go bit.
// Functional notes
// - Encode scans from bit 0 upward
// - Index in bits 3..0, upper bits zero
// - Zero source gives zero, sets zero flag
// - Encode overflow when several bits set
// - Encode overflow leaves trap bit alone
// - Zero flag follows written result
// - Convert packed BCD to binary
// - Word source holds four digits
// - Math source: four low, one high digit
// - Convert overflow: bad digit or above 32767
// - Convert overflow also sets minor error
`timescale 1ns/1ps
module pbc_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic irq_o
);
  typedef enum logic [1:0] {PBC_IDLE, PBC_EXEC} pbc_state_t;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = wr_i && (a == off);
  endfunction

  function automatic pbc_pkg::pbc_result_t do_encode(input logic [15:0] src);
    pbc_pkg::pbc_result_t r;
    int unsigned cnt;
    r = '0;
    cnt = 0;
    for (int i = 15; i >= 0; i--)
    begin
      if (src[i])
      begin
        r.value = {12'h000, 4'(i)};
      end
    end
    for (int i = 0; i < 16; i++)
    begin
      cnt = cnt + 32'(src[i]);
    end
    r.flags.ovf = (cnt > 1);
    r.flags.zero = (r.value == 16'h0000);
    r.flags.carry = 1'b0;
    r.flags.sign = 1'b0;
    r.minor_err = 1'b0;
    return r;
  endfunction

  function automatic pbc_pkg::pbc_result_t do_bcd(input logic [15:0] lo, input logic [15:0] hi,
                                                   input logic math);
    pbc_pkg::pbc_result_t r;
    logic bad;
    logic [16:0] acc;
    logic [3:0] d;
    r = '0;
    bad = 1'b0;
    // Top digit only from the high math word; word source keeps four digits
    d = math ? hi[3:0] : 4'h0;
    if (math && (hi[15:4] != 12'h000 || d > pbc_pkg::BCD_MAX_DIGIT))
    begin
      bad = 1'b1;
    end
    acc = 17'(d);
    for (int k = 3; k >= 0; k--)
    begin
      d = lo[4*k +: 4];
      if (d > pbc_pkg::BCD_MAX_DIGIT)
      begin
        bad = 1'b1;
      end
      acc = 17'(acc * 17'd10) + 17'(d);
    end
    r.flags.ovf = bad || (acc > pbc_pkg::MAX_POS);
    r.minor_err = r.flags.ovf;
    // Overflowed results are masked to 15 bits; value is undefined anyway
    r.value = {1'b0, acc[14:0]};
    r.flags.zero = (r.value == 16'h0000);
    r.flags.carry = 1'b0;
    r.flags.sign = 1'b0;
    return r;
  endfunction

  // Operand words; software owns them, the datapath only reads them
  logic [15:0] src_q, src_d, lo_q, lo_d, hi_q, hi_d;
  // Sequencer: one busy cycle per accepted go
  pbc_state_t st_q, st_d;
  logic bcd_q, bcd_d, math_q, math_d;
  // Results of the last op
  logic [15:0] dest_q, dest_d, arith_q, arith_d;
  logic minor_q, minor_d;
  // Sticky event bits and their mask
  logic [1:0] ist_q, ist_d, imask_q, imask_d;
  logic irq_d;
  // Read port
  logic [15:0] rdata_d;
  logic go;
  logic exec;
  pbc_pkg::pbc_result_t res;

  // Registered operands: a write in the busy cycle lands after the result
  always_comb
  begin
    res = bcd_q ? do_bcd(math_q ? lo_q : src_q, hi_q, math_q) : do_encode(src_q);
    go = hit(addr_i, pbc_pkg::OFF_CMD) && wdata_i[pbc_pkg::CMD_GO_BIT];
    exec = (st_q == PBC_EXEC);
  end

  always_comb
  begin
    src_d = src_q;
    lo_d = lo_q;
    hi_d = hi_q;
    if (hit(addr_i, pbc_pkg::OFF_SRC))
    begin
      src_d = wdata_i;
    end
    if (hit(addr_i, pbc_pkg::OFF_MATH_LO))
    begin
      lo_d = wdata_i;
    end
    if (hit(addr_i, pbc_pkg::OFF_MATH_HI))
    begin
      hi_d = wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      src_q <= pbc_pkg::RST_WORD;
      lo_q <= pbc_pkg::RST_WORD;
      hi_q <= pbc_pkg::RST_WORD;
    end
    else
    begin
      src_q <= src_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

  // A go seen while busy is dropped, not queued
  always_comb
  begin
    st_d = st_q;
    bcd_d = bcd_q;
    math_d = math_q;
    case (st_q)
      PBC_IDLE:
      begin
        if (go)
        begin
          bcd_d = wdata_i[pbc_pkg::CMD_BCD_BIT];
          math_d = wdata_i[pbc_pkg::CMD_MATH_BIT];
          st_d = PBC_EXEC;
        end
      end
      PBC_EXEC:
      begin
        st_d = PBC_IDLE;
      end
      default:
      begin
        st_d = PBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= PBC_IDLE;
      bcd_q <= 1'b0;
      math_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      bcd_q <= bcd_d;
      math_q <= math_d;
    end
  end

  // The op overrides bits 3..0 of a same-cycle ARITH write; a same-cycle MINOR write stands unless minor_err sets the bit
  always_comb
  begin
    dest_d = dest_q;
    arith_d = arith_q;
    minor_d = minor_q;
    if (hit(addr_i, pbc_pkg::OFF_ARITH))
    begin
      arith_d = wdata_i;
    end
    if (hit(addr_i, pbc_pkg::OFF_MINOR))
    begin
      minor_d = wdata_i[0];
    end
    if (exec)
    begin
      dest_d = res.value;
      arith_d[3:0] = res.flags;
      // Encode never raises minor_err, so the trap bit keeps its value
      if (res.minor_err)
      begin
        minor_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dest_q <= pbc_pkg::RST_WORD;
      arith_q <= pbc_pkg::RST_WORD;
      minor_q <= 1'b0;
    end
    else
    begin
      dest_q <= dest_d;
      arith_q <= arith_d;
      minor_q <= minor_d;
    end
  end

  always_comb
  begin
    imask_d = imask_q;
    ist_d = ist_q;
    if (hit(addr_i, pbc_pkg::OFF_IRQ_MASK))
    begin
      imask_d = wdata_i[1:0];
    end
    if (hit(addr_i, pbc_pkg::OFF_IRQ_STAT))
    begin
      ist_d = ist_q & ~wdata_i[1:0];
    end
    // Set wins over a same-cycle clear, so no event is lost
    if (exec)
    begin
      ist_d[pbc_pkg::IRQ_DONE] = 1'b1;
      if (res.flags.ovf)
      begin
        ist_d[pbc_pkg::IRQ_OVF] = 1'b1;
      end
    end
    // Built from next state so the pin does not trail the status bits
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ist_q <= pbc_pkg::RST_IRQ;
      imask_q <= pbc_pkg::RST_IRQ;
      irq_o <= 1'b0;
    end
    else
    begin
      ist_q <= ist_d;
      imask_q <= imask_d;
      irq_o <= irq_d;
    end
  end

  // Read data stand for one cycle only and are zero otherwise
  always_comb
  begin
    rdata_d = 16'h0000;
    if (rd_i)
    begin
      case (addr_i)
        pbc_pkg::OFF_SRC: rdata_d = src_q;
        pbc_pkg::OFF_MATH_LO: rdata_d = lo_q;
        pbc_pkg::OFF_MATH_HI: rdata_d = hi_q;
        pbc_pkg::OFF_CMD: rdata_d = {15'h0000, exec};
        pbc_pkg::OFF_DEST: rdata_d = dest_q;
        pbc_pkg::OFF_ARITH: rdata_d = arith_q;
        pbc_pkg::OFF_MINOR: rdata_d = {15'h0000, minor_q};
        pbc_pkg::OFF_IRQ_STAT: rdata_d = {14'h0000, ist_q};
        pbc_pkg::OFF_IRQ_MASK: rdata_d = {14'h0000, imask_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 16'h0000;
    end
    else
    begin
      rdata_o <= rdata_d;
    end
  end
endmodule // pbc_core

// *** rtl/pbc_pkg.sv ***
// Package for the priority encode / BCD convert datapath.
// Assumes a single 200 MHz clock domain and a plain register port.
package pbc_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] OFF_SRC = 4'h0;
  localparam logic [3:0] OFF_MATH_LO = 4'h1;
  localparam logic [3:0] OFF_MATH_HI = 4'h2;
  localparam logic [3:0] OFF_CMD = 4'h3;
  localparam logic [3:0] OFF_DEST = 4'h4;
  localparam logic [3:0] OFF_ARITH = 4'h5;
  localparam logic [3:0] OFF_MINOR = 4'h6;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h7;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h8;
  // Command field positions
  localparam int unsigned CMD_GO_BIT = 0;
  localparam int unsigned CMD_BCD_BIT = 1;
  localparam int unsigned CMD_MATH_BIT = 2;
  // Arithmetic status bit positions
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_OVF = 1;
  localparam int unsigned ST_ZERO = 2;
  localparam int unsigned ST_SIGN = 3;
  // Interrupt status bit positions
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_OVF = 1;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // Limits
  localparam logic [16:0] MAX_POS = 17'h07fff;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;

  typedef struct packed {
    logic sign;
    logic zero;
    logic ovf;
    logic carry;
  } pbc_flags_t;

  typedef struct packed {
    logic [15:0] value;
    pbc_flags_t flags;
    logic minor_err;
  } pbc_result_t;
endpackage

// *** bench/pbc_monitor.sv ***
// Port checker for pbc_core.
// Assumes each op is read back as DEST, ARITH, MINOR in that order.
`timescale 1ns/1ps
module pbc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic irq_o
);
  logic rv_q, enc_q, ov_q;
  logic [3:0] ra_q;
  logic [15:0] dq_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Remembers the last read and op so reads can be judged together
  always_ff @(posedge clk_i)
  begin
    rv_q <= rd_i;
    ra_q <= addr_i;
    if (wr_i && addr_i == pbc_pkg::OFF_CMD && wdata_i[0])
      enc_q <= !wdata_i[1];
    if (rv_q && ra_q == pbc_pkg::OFF_DEST)
      dq_q <= rdata_o;
    if (rv_q && ra_q == pbc_pkg::OFF_ARITH)
      ov_q <= rdata_o[1] && !enc_q;
  end
  property p_idle; !rv_q |-> rdata_o == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_unmap; rv_q && ra_q > 4'h8 |-> rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_enc_hi; rv_q && ra_q == pbc_pkg::OFF_DEST && enc_q |-> rdata_o[15:4] == 12'h000;
  endproperty
  a_enc_hi: assert property (p_enc_hi) else $error("index upper bits set");
  property p_pos; rv_q && ra_q == pbc_pkg::OFF_DEST |-> !rdata_o[15]; endproperty
  a_pos: assert property (p_pos) else $error("result above 15 bits");
  property p_cs; rv_q && ra_q == pbc_pkg::OFF_ARITH |-> !rdata_o[0] && !rdata_o[3]; endproperty
  a_cs: assert property (p_cs) else $error("carry or sign set");
  property p_zero; rv_q && ra_q == pbc_pkg::OFF_ARITH |-> rdata_o[2] == (dq_q == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_minor; rv_q && ra_q == pbc_pkg::OFF_MINOR && ov_q |-> rdata_o[0]; endproperty
  a_minor: assert property (p_minor) else $error("minor error missing");
  property p_irq; wr_i && addr_i == pbc_pkg::OFF_IRQ_MASK && wdata_i == 16'h0000 |-> ##2 !irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
  c_ovf: cover property (rv_q && ra_q == pbc_pkg::OFF_ARITH && rdata_o[1]);
  c_minor: cover property (rv_q && ra_q == pbc_pkg::OFF_MINOR && rdata_o[0]);
  c_irq: cover property (irq_o);
endmodule // pbc_monitor
bind pbc_core pbc_monitor i_pbc_monitor (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .irq_o);

// *** bench/tb_top.sv ***
// Bench for pbc_core: encode and BCD convert through the register port.
// Assumes results two edges after go and read data one cycle after rd_i.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) \
  begin err_total++; $display("ERROR %0t mismatch", $time); end end
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_p = 1'b0;
  logic irq_o, irq_x = 1'b0, mnr = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, r, exq[$];
  logic [50:0] tv [7] = '{{3'h3, 16'h9999, 32'h0}, {3'h3, 16'h12a4, 32'h0},
    {3'h7, 16'h0, 16'h2767, 16'h0003}, {3'h7, 16'h0, 16'h2768, 16'h0003},
    {3'h1, 16'h00f0, 32'h0}, {3'h7, 16'h0, 16'h0000, 16'h0010}, {3'h3, 16'h0, 32'h0}};
  int err_total = 0, samples_checked = 0;
  pbc_core i_pbc_core (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o);
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (rd_p)
      `CHK(rdata_o, exq.pop_front())
    rd_p <= rd_i;
  end
  // A read notes its expected data in d
  task automatic bus(input logic w, r, input logic [3:0] a, input logic [15:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    if (r)
      exq.push_back(d);
    @(posedge clk_i);
  endtask
  task automatic op(input logic [2:0] c, input logic [15:0] s, lo, hi);
    logic [19:0] w;
    int v;
    logic [15:0] d;
    logic ov;
    v = 0;
    d = 16'h0000;
    w = c[2] ? {hi[3:0], lo} : {4'h0, s};
    if (c[1])
    begin
      ov = c[2] && hi[15:4] != 12'h000;
      for (int k = 4; k >= 0; k--)
      begin
        ov |= w[4*k+:4] > 4'h9;
        v = v * 10 + int'(w[4*k+:4]);
      end
      ov |= v > 32767;
      d = 16'(v[14:0]);
      mnr |= ov;
    end
    else
    begin
      for (int i = 15; i >= 0; i--)
        if (s[i])
          d = 16'(i);
      ov = $countones(s) > 1;
    end
    bus(1'b1, 1'b0, pbc_pkg::OFF_SRC, s);
    // Source seen unchanged on a second look before go
    bus(1'b0, 1'b1, pbc_pkg::OFF_SRC, s);
    bus(1'b1, 1'b0, pbc_pkg::OFF_MATH_LO, lo);
    bus(1'b1, 1'b0, pbc_pkg::OFF_MATH_HI, hi);
    bus(1'b1, 1'b0, pbc_pkg::OFF_CMD, {13'h0, c});
    bus(1'b0, 1'b1, pbc_pkg::OFF_CMD, 16'h0001);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    bus(1'b0, 1'b1, pbc_pkg::OFF_DEST, d);
    bus(1'b0, 1'b1, pbc_pkg::OFF_ARITH, {12'h000, 1'b0, d == 0, ov, 1'b0});
    bus(1'b0, 1'b1, pbc_pkg::OFF_MINOR, {15'h0, mnr});
    bus(1'b0, 1'b1, pbc_pkg::OFF_IRQ_STAT, {14'h0, ov, 1'b1});
    bus(1'b1, 1'b0, pbc_pkg::OFF_IRQ_STAT, 16'h0003);
    `CHK(irq_o, irq_x)
    repeat (2) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    `CHK(irq_o, 1'b0)
  endtask
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(1));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    op(3'h1, 16'h0000, 16'h0000, 16'h0000);
    bus(1'b1, 1'b0, pbc_pkg::OFF_IRQ_MASK, 16'h0001);
    irq_x = 1'b1;
    for (int i = 0; i < 16; i++)
      op(3'h1, 16'(($urandom << (i + 1)) | (32'h1 << i)), 16'h0, 16'h0);
    foreach (tv[j])
      op(tv[j][50:48], tv[j][47:32], tv[j][31:16], tv[j][15:0]);
    // Four digits through the math words with the high word cleared after the low word
    op(3'h7, 16'h0000, 16'h1234, 16'h0000);
    bus(1'b1, 1'b0, pbc_pkg::OFF_MINOR, 16'h0000);
    mnr = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      v_bcd(r);
      op({i[0], 2'h3}, r, r, 16'($urandom % 4));
    end
    bus(1'b1, 1'b0, pbc_pkg::OFF_IRQ_MASK, 16'h0000);
    bus(1'b0, 1'b1, 4'hf, 16'h0000);
    repeat (3) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    give_verdict();
  end
  task automatic v_bcd(output logic [15:0] b);
    int n;
    n = $urandom % 10000;
    b = {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
  endtask
endmodule // tb_top
